// ==== core/pdmac_top.sv ====
// Added by the designer: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module pdmac_top
  import pdmac_pkg::*;
#(
  parameter bit HALF_DUPLEX = 1'b0
) (
  input  wire logic           ref_clk,
  input  wire logic           arst_n,
  input  wire logic           hsel,
  input  wire logic [31:0]    haddr,
  input  wire logic [1:0]     htrans,
  input  wire logic           hwrite,
  input  wire logic [2:0]     hsize,
  input  wire logic [31:0]    hwdata,
  input  wire logic           hready,
  output logic                hreadyout,
  output logic [31:0]         hrdata,
  output logic                hresp,
  input  wire logic [1:0]     item_size,
  input  wire logic           rx_ready,
  input  wire logic [31:0]    rx_data,
  output logic                rx_take,
  input  wire logic           tx_ready,
  output logic [31:0]         tx_data,
  output logic                tx_put,
  output pdmac_mem_req_t      mem_req,
  input  wire logic           mem_done,
  input  wire logic [31:0]    mem_rdata,
  output logic                rx_enabled,
  output logic                tx_enabled,
  output logic                rx_block_done,
  output logic                rx_all_buffers_full,
  output logic                tx_block_done,
  output logic                tx_all_buffers_empty
);

  // Storage slot used by the transmit names; half duplex folds it onto 0.
  localparam int TXI = HALF_DUPLEX ? 0 : 1;

  logic           hreadyout_q;
  logic [31:0]    hrdata_q;
  logic           wr_pend_q;
  logic           rd_pend_q;
  logic [11:0]    addr_q;
  logic           rx_en_q;
  logic           tx_en_q;
  logic [31:0]    ptr_q  [2];
  logic [31:0]    nptr_q [2];
  logic [15:0]    cnt_q  [2];
  logic [15:0]    ncnt_q [2];
  pdmac_state_t   state_q;
  logic           dir_q;
  logic [1:0]     size_q;
  pdmac_mem_req_t mem_req_q;
  logic           rx_take_q;
  logic           tx_put_q;
  logic [31:0]    tx_data_q;
  logic [1:0]     end_q;
  logic [1:0]     full_q;

  logic           acc;
  logic           w_rxp, w_rxc, w_txp, w_txc;
  logic           w_rxnp, w_rxnc, w_txnp, w_txnc, w_ctl;
  logic [1:0]     wp, wc, wnp, wnc;
  logic           rx_set, rx_clr, tx_set, tx_clr;
  logic           adv;
  logic           aidx;
  logic           last;
  logic [31:0]    inc;
  logic           rx_go, tx_go;
  logic [31:0]    rdata_d;

  assign acc = hsel && hready && htrans[PDMAC_HTRANS_ACTIVE];

  // Address phase is captured; writes commit in the data phase.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 12'h000;
    end else begin
      wr_pend_q <= acc && hwrite;
      rd_pend_q <= acc && !hwrite;
      if (acc) begin
        addr_q <= haddr[11:0];
      end
    end
  end

  // Reads take one wait state so that a write just before is visible.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      hreadyout_q <= 1'b1;
      hrdata_q    <= 32'h0000_0000;
    end else begin
      hreadyout_q <= !(acc && !hwrite);
      if (rd_pend_q) begin
        hrdata_q <= rdata_d;
      end
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (addr_q == PDMAC_OFF_RX_PTR) begin
      rdata_d = ptr_q[0];
    end else if (addr_q == PDMAC_OFF_RX_CNT) begin
      rdata_d = {16'h0000, cnt_q[0]};
    end else if (addr_q == PDMAC_OFF_TX_PTR) begin
      rdata_d = ptr_q[TXI];
    end else if (addr_q == PDMAC_OFF_TX_CNT) begin
      rdata_d = {16'h0000, cnt_q[TXI]};
    end else if (addr_q == PDMAC_OFF_RX_NPTR) begin
      rdata_d = nptr_q[0];
    end else if (addr_q == PDMAC_OFF_RX_NCNT) begin
      rdata_d = {16'h0000, ncnt_q[0]};
    end else if (addr_q == PDMAC_OFF_TX_NPTR) begin
      rdata_d = nptr_q[TXI];
    end else if (addr_q == PDMAC_OFF_TX_NCNT) begin
      rdata_d = {16'h0000, ncnt_q[TXI]};
    end else if (addr_q == PDMAC_OFF_STATE) begin
      rdata_d[PDMAC_BIT_RX_EN] = rx_en_q;
      rdata_d[PDMAC_BIT_TX_EN] = tx_en_q;
    end
  end

  assign w_rxp  = wr_pend_q && (addr_q == PDMAC_OFF_RX_PTR);
  assign w_rxc  = wr_pend_q && (addr_q == PDMAC_OFF_RX_CNT);
  assign w_txp  = wr_pend_q && (addr_q == PDMAC_OFF_TX_PTR);
  assign w_txc  = wr_pend_q && (addr_q == PDMAC_OFF_TX_CNT);
  assign w_rxnp = wr_pend_q && (addr_q == PDMAC_OFF_RX_NPTR);
  assign w_rxnc = wr_pend_q && (addr_q == PDMAC_OFF_RX_NCNT);
  assign w_txnp = wr_pend_q && (addr_q == PDMAC_OFF_TX_NPTR);
  assign w_txnc = wr_pend_q && (addr_q == PDMAC_OFF_TX_NCNT);
  assign w_ctl  = wr_pend_q && (addr_q == PDMAC_OFF_CTRL);

  // Both names of a register pair land in the same slot on half duplex.
  assign wp  = {w_txp  && (TXI == 1), w_rxp  || (w_txp  && (TXI == 0))};
  assign wc  = {w_txc  && (TXI == 1), w_rxc  || (w_txc  && (TXI == 0))};
  assign wnp = {w_txnp && (TXI == 1), w_rxnp || (w_txnp && (TXI == 0))};
  assign wnc = {w_txnc && (TXI == 1), w_rxnc || (w_txnc && (TXI == 0))};

  assign rx_set = w_ctl && hwdata[PDMAC_BIT_RX_EN]
                  && !hwdata[PDMAC_BIT_RX_DIS];
  assign rx_clr = w_ctl && hwdata[PDMAC_BIT_RX_DIS];
  assign tx_set = w_ctl && hwdata[PDMAC_BIT_TX_EN]
                  && !hwdata[PDMAC_BIT_TX_DIS]
                  && !(HALF_DUPLEX && hwdata[PDMAC_BIT_RX_EN]);
  assign tx_clr = w_ctl && hwdata[PDMAC_BIT_TX_DIS];

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_en_q <= 1'b0;
    end else if (rx_clr || (HALF_DUPLEX && tx_clr)
                 || (HALF_DUPLEX && tx_set)) begin
      rx_en_q <= 1'b0;
    end else if (rx_set) begin
      rx_en_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_en_q <= 1'b0;
    end else if (tx_clr || (HALF_DUPLEX && (rx_clr || rx_set))) begin
      tx_en_q <= 1'b0;
    end else if (tx_set) begin
      tx_en_q <= 1'b1;
    end
  end

  assign rx_go = rx_en_q && rx_ready && (cnt_q[0] != PDMAC_RST_CNT);
  assign tx_go = tx_en_q && tx_ready && (cnt_q[TXI] != PDMAC_RST_CNT);
  assign adv   = (state_q == PDMAC_WAIT) && mem_done;
  assign aidx  = dir_q && (TXI == 1);
  assign last  = (cnt_q[aidx] == 16'h0001);
  assign inc   = 32'h0000_0001 << size_q;

  // One memory access at a time; receive is served first.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q   <= PDMAC_IDLE;
      dir_q     <= 1'b0;
      size_q    <= PDMAC_SZ_BYTE;
      mem_req_q <= '0;
      rx_take_q <= 1'b0;
      tx_put_q  <= 1'b0;
      tx_data_q <= 32'h0000_0000;
    end else begin
      rx_take_q <= 1'b0;
      tx_put_q  <= 1'b0;
      case (state_q)
        PDMAC_IDLE: begin
          if (rx_go || tx_go) begin
            state_q         <= PDMAC_WAIT;
            dir_q           <= !rx_go;
            size_q          <= item_size;
            rx_take_q       <= rx_go;
            mem_req_q.valid <= 1'b1;
            mem_req_q.write <= rx_go;
            mem_req_q.addr  <= rx_go ? ptr_q[0] : ptr_q[TXI];
            mem_req_q.size  <= item_size;
            mem_req_q.wdata <= rx_data;
          end
        end
        PDMAC_WAIT: begin
          if (mem_done) begin
            state_q         <= PDMAC_IDLE;
            mem_req_q.valid <= 1'b0;
            if (dir_q) begin
              tx_data_q <= mem_rdata;
              tx_put_q  <= 1'b1;
            end
          end
        end
        default: begin
          state_q <= PDMAC_IDLE;
        end
      endcase
    end
  end

  // A bus write to a slot takes priority over the engine's own update.
  for (genvar i = 0; i < 2; i++) begin : g_slot
    logic hit;
    assign hit = adv && (aidx == i[0]);

    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        ptr_q[i] <= PDMAC_RST_PTR;
      end else if (wp[i]) begin
        ptr_q[i] <= hwdata;
      end else if (hit && last && (ncnt_q[i] != PDMAC_RST_CNT)) begin
        ptr_q[i] <= nptr_q[i];
      end else if (hit) begin
        ptr_q[i] <= ptr_q[i] + inc;
      end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        cnt_q[i] <= PDMAC_RST_CNT;
      end else if (wc[i]) begin
        cnt_q[i] <= hwdata[15:0];
      end else if (hit && last) begin
        cnt_q[i] <= ncnt_q[i];
      end else if (hit) begin
        cnt_q[i] <= cnt_q[i] - 16'h0001;
      end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        nptr_q[i] <= PDMAC_RST_PTR;
      end else if (wnp[i]) begin
        nptr_q[i] <= hwdata;
      end else if (hit && last && (ncnt_q[i] != PDMAC_RST_CNT)) begin
        nptr_q[i] <= PDMAC_RST_PTR;
      end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        ncnt_q[i] <= PDMAC_RST_CNT;
      end else if (wnc[i]) begin
        ncnt_q[i] <= hwdata[15:0];
      end else if (hit && last) begin
        ncnt_q[i] <= PDMAC_RST_CNT;
      end
    end
  end

  // Flags per direction; a new event wins over a clearing write.
  for (genvar d = 0; d < 2; d++) begin : g_flag
    logic set_end, set_full, clr;
    assign set_end  = adv && (dir_q == d[0]) && last;
    assign set_full = set_end && (ncnt_q[aidx] == PDMAC_RST_CNT);
    assign clr = (d == 0)
                 ? ((w_rxc || w_rxnc) && (hwdata[15:0] != PDMAC_RST_CNT))
                 : ((w_txc || w_txnc) && (hwdata[15:0] != PDMAC_RST_CNT));

    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        end_q[d]  <= 1'b0;
        full_q[d] <= 1'b0;
      end else begin
        end_q[d]  <= set_end || (end_q[d] && !clr);
        full_q[d] <= set_full || (full_q[d] && !clr);
      end
    end
  end

  assign hreadyout            = hreadyout_q;
  assign hrdata               = hrdata_q;
  assign hresp                = 1'b0;
  assign rx_take              = rx_take_q;
  assign tx_put               = tx_put_q;
  assign tx_data              = tx_data_q;
  assign mem_req              = mem_req_q;
  assign rx_enabled           = rx_en_q;
  assign tx_enabled           = tx_en_q;
  assign rx_block_done        = end_q[0];
  assign rx_all_buffers_full  = full_q[0];
  assign tx_block_done        = end_q[1];
  assign tx_all_buffers_empty = full_q[1];

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_rx_step;
    adv && !dir_q && !wp[0] && !wc[0] && !wnc[0];
  endsequence

  sequence s_state_read;
    acc && !hwrite && (haddr[11:0] == PDMAC_OFF_STATE) && !wr_pend_q;
  endsequence

  a_rx_enable_set: assert property (
    rx_set && !(HALF_DUPLEX && tx_clr) |=> rx_en_q
  ) else $error("receive enable write did not enable");
  a_rx_disable_wins: assert property (
    rx_clr |=> !rx_en_q
  ) else $error("receive disable write did not disable");
  a_tx_enable_set: assert property (
    w_ctl && hwdata[PDMAC_BIT_TX_EN] && !hwdata[PDMAC_BIT_TX_DIS]
    && !hwdata[PDMAC_BIT_RX_EN] && !hwdata[PDMAC_BIT_RX_DIS] |=> tx_en_q
  ) else $error("transmit enable write did not enable");
  a_tx_disable_wins: assert property (
    tx_clr |=> !tx_en_q
  ) else $error("transmit disable write did not disable");
  a_half_exclusive: assert property (
    HALF_DUPLEX |-> !(rx_en_q && tx_en_q)
  ) else $error("both directions enabled on half duplex");
  a_half_cross_off: assert property (
    HALF_DUPLEX && tx_clr |=> !rx_en_q && !tx_en_q
  ) else $error("transmit disable left receive on");
  a_state_read_bits: assert property (
    s_state_read ##1 !wr_pend_q |=> !$past(hreadyout_q)
    && hreadyout_q && (hrdata_q[PDMAC_BIT_RX_EN] == $past(rx_en_q))
    && (hrdata_q[PDMAC_BIT_TX_EN] == $past(tx_en_q))
  ) else $error("status read does not show enable state");
  a_rx_ptr_advance: assert property (
    (s_rx_step and (!last)) |=> (ptr_q[0] == $past(ptr_q[0]) + $past(inc))
    && (cnt_q[0] == $past(cnt_q[0]) - 16'h0001)
  ) else $error("receive pointer or count did not step");
  a_rx_reload: assert property (
    (s_rx_step and (last && (ncnt_q[0] != PDMAC_RST_CNT) && !wnp[0]))
    |=> (cnt_q[0] == $past(ncnt_q[0])) && (ptr_q[0] == $past(nptr_q[0]))
    && (ncnt_q[0] == PDMAC_RST_CNT) && (nptr_q[0] == PDMAC_RST_PTR)
  ) else $error("receive reload from next registers failed");
  a_rx_flags_set: assert property (
    (s_rx_step and last) |=> rx_block_done
    && (rx_all_buffers_full == ($past(ncnt_q[0]) == PDMAC_RST_CNT
                                || $past(full_q[0])))
  ) else $error("receive end flags wrong at zero count");
  a_no_zero_start: assert property (
    rx_take_q |-> $past(cnt_q[0]) != PDMAC_RST_CNT && $past(rx_en_q)
  ) else $error("receive started with zero count or disabled");
  a_tx_needs_count: assert property (
    $rose(mem_req_q.valid) && !mem_req_q.write
    |-> $past(cnt_q[TXI]) != PDMAC_RST_CNT && $past(tx_en_q)
  ) else $error("transmit started with zero count or disabled");
  a_half_alias: assert property (
    HALF_DUPLEX && w_txc |=> cnt_q[0] == $past(hwdata[15:0])
  ) else $error("transmit count write missed shared storage");

endmodule : pdmac_top

// ==== core/pdmac_pkg.sv ====
package pdmac_pkg;

  // Register byte offsets inside the peripheral window.
  localparam logic [11:0] PDMAC_OFF_RX_PTR   = 12'h100;
  localparam logic [11:0] PDMAC_OFF_RX_CNT   = 12'h104;
  localparam logic [11:0] PDMAC_OFF_TX_PTR   = 12'h108;
  localparam logic [11:0] PDMAC_OFF_TX_CNT   = 12'h10C;
  localparam logic [11:0] PDMAC_OFF_RX_NPTR  = 12'h110;
  localparam logic [11:0] PDMAC_OFF_RX_NCNT  = 12'h114;
  localparam logic [11:0] PDMAC_OFF_TX_NPTR  = 12'h118;
  localparam logic [11:0] PDMAC_OFF_TX_NCNT  = 12'h11C;
  localparam logic [11:0] PDMAC_OFF_CTRL     = 12'h120;
  localparam logic [11:0] PDMAC_OFF_STATE    = 12'h124;

  // Field positions of transfer_control and transfer_state.
  localparam int PDMAC_BIT_RX_EN  = 0;
  localparam int PDMAC_BIT_RX_DIS = 1;
  localparam int PDMAC_BIT_TX_EN  = 8;
  localparam int PDMAC_BIT_TX_DIS = 9;

  // Reset values.
  localparam logic [31:0] PDMAC_RST_PTR = 32'h0000_0000;
  localparam logic [15:0] PDMAC_RST_CNT = 16'h0000;

  // Item size codes: byte, half-word, word.
  localparam logic [1:0] PDMAC_SZ_BYTE = 2'h0;
  localparam logic [1:0] PDMAC_SZ_HALF = 2'h1;
  localparam logic [1:0] PDMAC_SZ_WORD = 2'h2;

  // AHB transfer type bit that marks NONSEQ or SEQ.
  localparam int PDMAC_HTRANS_ACTIVE = 1;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [1:0]  size;
    logic [31:0] wdata;
  } pdmac_mem_req_t;

  typedef enum logic {
    PDMAC_IDLE,
    PDMAC_WAIT
  } pdmac_state_t;

endpackage : pdmac_pkg

// ==== tb/pdmac_far_model.sv ====
`timescale 1ns/1ps
module pdmac_far_model
  import pdmac_pkg::*;
(
  input  wire logic           ref_clk,
  input  wire logic           arst_n,
  input  wire logic           rx_on,
  input  wire logic           tx_on,
  input  wire pdmac_mem_req_t mem_req,
  input  wire logic           rx_take,
  output logic                rx_ready,
  output logic [31:0]         rx_data,
  output logic                tx_ready,
  output logic                mem_done,
  output logic [31:0]         mem_rdata
);
  logic [1:0] wait_q;

  assign rx_ready = rx_on;
  assign tx_ready = tx_on;

  // Memory answers after zero to three wait cycles, drawn per access.
  // Read data outside the answer cycle toggles so stale data is caught.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_done  <= 1'b0;
      wait_q    <= 2'h0;
      mem_rdata <= 32'h0000_0000;
    end else begin
      mem_done  <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req.valid && !mem_done) begin
        if (wait_q == 2'h0) begin
          mem_done  <= 1'b1;
          mem_rdata <= mem_req.addr ^ 32'hA5A5_0000;
          wait_q    <= 2'($urandom);
        end else begin
          wait_q <= wait_q - 2'h1;
        end
      end
    end
  end

  // The holding register moves on to a new item once one is taken.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_data <= 32'h0000_0100;
    end else if (rx_take) begin
      rx_data <= rx_data + 32'h0001_3579;
    end
  end
endmodule : pdmac_far_model

// ==== tb/peripheral_dma_channel_regs_tb.sv ====
`timescale 1ns/1ps
module peripheral_dma_channel_regs_tb
  import pdmac_pkg::*;
;
  logic           ref_clk = 1'b0;
  logic           arst_n = 1'b0;
  logic           hsel = 1'b0;
  logic           hwrite = 1'b0;
  logic           rx_on = 1'b0;
  logic           tx_on = 1'b0;
  logic           tx_dir = 1'b0;
  logic [1:0]     htrans = 2'h0;
  logic [1:0]     item_size = 2'h0;
  logic [31:0]    haddr = 32'h0000_0000;
  logic [31:0]    hwdata = 32'h0000_0000;
  logic           hreadyout, hresp, rx_ready, tx_ready, rx_take, tx_put;
  logic           mem_done, rx_en, tx_en, rx_dn, rx_fl, tx_dn, tx_em;
  logic [31:0]    hrdata, rx_data, tx_data, mem_rdata, rd, rx_seen, tx_exp;
  logic [1:0]     fl;
  pdmac_mem_req_t mem_req;
  pdmac_mem_req_t mem_req_h;
  logic           hreadyout_h, tx_put_h, rx_en_h, tx_en_h;
  logic           rx_dn_h, rx_fl_h, tx_dn_h, tx_em_h;
  logic [31:0]    hrdata_h, tx_data_h, hwdata_h, rd_h, exp_addr, nb;
  logic [1:0]     fl_h;
  int             dones = 0;
  int             num_errors = 0;
  int             checks = 0;
  int             moved = 0;

  assign fl = tx_dir ? {tx_dn, tx_em} : {rx_dn, rx_fl};
  assign fl_h = tx_dir ? {tx_dn_h, tx_em_h} : {rx_dn_h, rx_fl_h};

  // Half duplex software never sets both enables in one control write.
  assign hwdata_h = (haddr[11:0] == PDMAC_OFF_CTRL && hwdata[0])
                    ? (hwdata & 32'hFFFF_FEFF) : hwdata;

  always #50 ref_clk = ~ref_clk;

  pdmac_top dut_u (
    .ref_clk(ref_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .item_size(item_size), .rx_ready(rx_ready),
    .rx_data(rx_data), .rx_take(rx_take), .tx_ready(tx_ready),
    .tx_data(tx_data), .tx_put(tx_put), .mem_req(mem_req),
    .mem_done(mem_done), .mem_rdata(mem_rdata), .rx_enabled(rx_en),
    .tx_enabled(tx_en), .rx_block_done(rx_dn), .rx_all_buffers_full(rx_fl),
    .tx_block_done(tx_dn), .tx_all_buffers_empty(tx_em)
  );

  pdmac_far_model far_u (
    .ref_clk(ref_clk), .arst_n(arst_n), .rx_on(rx_on), .tx_on(tx_on),
    .mem_req(mem_req), .rx_take(rx_take), .rx_ready(rx_ready),
    .rx_data(rx_data), .tx_ready(tx_ready), .mem_done(mem_done),
    .mem_rdata(mem_rdata)
  );

  pdmac_top #(.HALF_DUPLEX(1'b1)) dut_h_u (
    .ref_clk(ref_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata_h),
    .hready(hreadyout_h), .hreadyout(hreadyout_h), .hrdata(hrdata_h),
    .hresp(), .item_size(item_size), .rx_ready(rx_ready),
    .rx_data(rx_data), .rx_take(), .tx_ready(tx_ready),
    .tx_data(tx_data_h), .tx_put(tx_put_h), .mem_req(mem_req_h),
    .mem_done(mem_done), .mem_rdata(mem_rdata), .rx_enabled(rx_en_h),
    .tx_enabled(tx_en_h), .rx_block_done(rx_dn_h),
    .rx_all_buffers_full(rx_fl_h), .tx_block_done(tx_dn_h),
    .tx_all_buffers_empty(tx_em_h)
  );

  task automatic check(input string name, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic final_report;
    if (num_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  // Entered just after a rising edge; returns at the edge ending the data
  // phase, so calls chain back to back.
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {20'h00000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    rd_h = hrdata_h;
    check("hresp", {31'h0, hresp}, 32'h0000_0000);
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd_chk(input string n, input logic [11:0] a,
                        input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    check(n, rd, e);
    check({n, "_h"}, rd_h, e);
  endtask : rd_chk

  always @(posedge ref_clk) begin
    if (rx_take === 1'b1) begin
      moved++;
      rx_seen = rx_data;
    end
    if (tx_put === 1'b1) begin
      moved++;
      check("tx_data", tx_data, tx_exp);
    end
    if (tx_put_h === 1'b1)
      check("tx_data_h", tx_data_h, tx_exp);
    if (mem_done === 1'b1) begin
      check("mem_size", {30'h0, mem_req.size}, {30'h0, item_size});
      check("mem_addr", mem_req.addr, exp_addr);
      check("mem_addr_h", mem_req_h.addr, exp_addr);
      if (mem_req.write === 1'b1)
        check("mem_wdata", mem_req.wdata, rx_seen);
      else
        tx_exp = exp_addr ^ 32'hA5A5_0000;
      dones++;
      exp_addr = (dones == 2) ? nb : exp_addr + (32'h1 << item_size);
    end
  end

  initial begin
    logic [31:0] v;
    logic [11:0] a, off;
    logic        er, et, erh, eth;
    logic [31:0] tbl [4];
    int          n;
    tbl = '{32'h0000_0101, 32'h0000_0303, 32'h0000_0101, 32'h0000_0000};
    er = 1'b0;
    et = 1'b0;
    erh = 1'b0;
    eth = 1'b0;
    void'($urandom(55355));
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < 11; i++)
      rd_chk("reset", 12'(12'h100 + 4 * i), 32'h0000_0000);
    wr(12'h128, 32'hFFFF_FFFF);
    wr(PDMAC_OFF_STATE, 32'hFFFF_FFFF);
    rd_chk("unmapped", 12'h128, 32'h0000_0000);
    rd_chk("state_ro", PDMAC_OFF_STATE, 32'h0000_0000);
    for (int i = 0; i < 24; i++) begin
      v = $urandom;
      a = 12'(12'h100 + 4 * $urandom_range(7, 0));
      wr(a, v);
      rd_chk("reg", a, a[2] ? {16'h0000, v[15:0]} : v);
      bus(1'b0, a ^ 12'h008, 32'h0000_0000);
      check("alias_h", rd_h, a[2] ? {16'h0000, v[15:0]} : v);
    end
    // Enable model: a disable bit wins over the enable beside it.
    for (int i = 0; i < 24; i++) begin
      v = (i < 4) ? tbl[i] : $urandom;
      er = v[1] ? 1'b0 : (v[0] ? 1'b1 : er);
      et = v[9] ? 1'b0 : (v[8] ? 1'b1 : et);
      // Half duplex: either disable drops both, each enable drops the other.
      erh = (v[1] | v[9]) ? 1'b0 : (v[0] ? 1'b1 : (v[8] ? 1'b0 : erh));
      eth = (v[0] | v[1] | v[9]) ? 1'b0 : (v[8] ? 1'b1 : eth);
      wr(PDMAC_OFF_CTRL, v);
      bus(1'b0, PDMAC_OFF_STATE, 32'h0000_0000);
      check("state", rd, {23'h0, et, 7'h0, er});
      check("state_h", rd_h, {23'h0, eth, 7'h0, erh});
      check("rx_en", {31'h0, rx_en}, {31'h0, er});
      check("tx_en", {31'h0, tx_en}, {31'h0, et});
      check("rx_en_h", {31'h0, rx_en_h}, {31'h0, erh});
      check("tx_en_h", {31'h0, tx_en_h}, {31'h0, eth});
    end
    rd_chk("ctrl_wo", PDMAC_OFF_CTRL, 32'h0000_0000);
    wr(PDMAC_OFF_CTRL, 32'h0000_0202);
    for (int d = 0; d < 2; d++) begin
      for (int sz = 0; sz < 3; sz++) begin
        tx_dir = d[0];
        off = tx_dir ? 12'h008 : 12'h000;
        nb = $urandom & 32'hFFFF_FFF0;
        exp_addr = $urandom & 32'hFFFF_FFF0;
        item_size <= 2'(sz);
        moved = 0;
        dones = 0;
        wr(PDMAC_OFF_RX_PTR + off, exp_addr);
        wr(PDMAC_OFF_RX_CNT + off, 32'h0000_0002);
        wr(PDMAC_OFF_RX_NPTR + off, nb);
        wr(PDMAC_OFF_RX_NCNT + off, 32'h0000_0001);
        check("flag_clear", {30'h0, fl}, 32'h0000_0000);
        wr(PDMAC_OFF_CTRL, tx_dir ? 32'h0000_0100 : 32'h0000_0001);
        rx_on <= !tx_dir;
        tx_on <= tx_dir;
        n = 0;
        while (fl !== 2'b11 && n < 300) begin
          @(posedge ref_clk);
          n++;
        end
        repeat (12) @(posedge ref_clk);
        check("items", moved, 3);
        check("flags", {30'h0, fl}, 32'h0000_0003);
        check("flags_h", {30'h0, fl_h}, 32'h0000_0003);
        check("mem_items", dones, 3);
        rd_chk("ptr", PDMAC_OFF_RX_PTR + off, nb + (32'h1 << sz));
        rd_chk("cnt", PDMAC_OFF_RX_CNT + off, 32'h0000_0000);
        rd_chk("nptr", PDMAC_OFF_RX_NPTR + off, 32'h0000_0000);
        rd_chk("ncnt", PDMAC_OFF_RX_NCNT + off, 32'h0000_0000);
        rx_on <= 1'b0;
        tx_on <= 1'b0;
        wr(PDMAC_OFF_CTRL, 32'h0000_0202);
      end
    end
    final_report;
  end

  initial begin
    #4000000;
    num_errors++;
    final_report;
  end
endmodule : peripheral_dma_channel_regs_tb
